// File: sstc_far_side.sv
// far-side model: spin oscillator, interface sun pulse, mode change and a/d start sources
`timescale 1ns/1ps
module sstc_far_side #(
  parameter int OSC_HALF = 2
) (
  input  wire logic clock,
  output logic      osc_in,
  output logic      iface_sun_pulse,
  output logic      delayed_sun_mode_toggle,
  output logic      ad_start
);
  int ph;
  initial begin
    osc_in = 1'b0;
    iface_sun_pulse = 1'b0;
    delayed_sun_mode_toggle = 1'b0;
    ad_start = 1'b0;
    ph = 0;
  end
  // square wave locked to the clock, so one count is exactly 4*OSC_HALF clocks
  always @(posedge clock) begin
    #1;
    ph = (ph + 1) % OSC_HALF;
    if (ph == 0) osc_in = ~osc_in;
  end
  // held 4 clocks: past the 2-clock minimum of the input synchronisers
  task automatic strobe(input int sel);
    @(posedge clock);
    #1;
    if (sel == 0) iface_sun_pulse = 1'b1;
    else if (sel == 1) delayed_sun_mode_toggle = 1'b1;
    else ad_start = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    iface_sun_pulse = 1'b0;
    delayed_sun_mode_toggle = 1'b0;
    ad_start = 1'b0;
    repeat (4) @(posedge clock);
    #1;
  endtask
endmodule // sstc_far_side

// File: sstc_pkg.sv
// package: constants and carrier types for the spin sector timing control block
package sstc_pkg;
  localparam int CNT_W        = 11;
  localparam int SECTOR_W     = 7;
  localparam int SECTOR_LSB   = 4;
  localparam int CLK_HZ       = 40000000;
  localparam int AD_PULSE_NS  = 4000;
  localparam int AD_START_NS  = 8000;
  localparam int AD_RATE_HZ   = 81920;
  localparam int DELAY_MS     = 32;
  localparam int AD_PULSE_CYC = (AD_PULSE_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int AD_START_CYC = (AD_START_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int AD_PERIOD_CYC = CLK_HZ / AD_RATE_HZ;
  localparam int DELAY_CYC    = DELAY_MS * (CLK_HZ / 1000);
  localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;
  localparam logic [CNT_W-1:0] CNT_LAST = 11'h7ff;

  typedef struct packed {
    logic sec_0_15;
    logic sec_1;
    logic sec_2_7;
    logic sec_10;
    logic sec_15;
    logic sec_64_79;
    logic sec_16_80;
    logic sec_selected;
  } sstc_strobe_t;

  typedef struct packed {
    logic overflow;
    logic stage1;
    logic stage2;
  } sstc_lock_t;
endpackage

// File: sstc_top.sv
// module: revolution counter, frequency lock, sun pulse delay path and a/d clock
`timescale 1ns/1ps
// Functional notes
// - count oscillator ticks in an eleven-bit counter, 2048 counts per revolution.
// - every sun pulse clears the revolution counter to zero.
// - every sun pulse realigns the oscillator tick phase.
// - sun pulse one-shot clears counter and overflow flag.
// - counter wrapping before next sun pulse sets the overflow flag.
// - with overflow, first sun pulse sets stage two, second sets stage one.
// - stage two is the steering command: set lowers, clear raises frequency.
// - without overflow the next two sun pulses clear both stages in turn.
// - both stage outputs are available as lock status.
// - oscillator squared by a toggle flop whose inverse clocks the counter; the a/d logic runs from the system clock.
// - a/d clock gives 4 us pulses at 81.92 kilopulses per second.
// - first a/d pulse comes 8 us after the start command.
// - mode-change pulse sets path select, passing interface sun pulse straight through.
// - direct path passes interface pulse and blocks the delayed one-shot.
// - each interface sun pulse toggles a flop whose rise starts the delay.
// - the falling end of the delay interval fires a one-shot.
// - next mode-change pulse clears path select, routing the delayed pulse out.
// - delayed mode issues sun pulse 32 ms after every second interface pulse.
// - revolution divided into 128 sectors numbered 0 to 127.
// - each sector is 16 counts, sector number is upper seven bits.
// - counter bits are decoded into sector strobes.
module sstc_top #(
  parameter int DELAY_CYCLES = sstc_pkg::DELAY_CYC
) (
  input  wire logic                         clock,
  input  wire logic                         rst_n,
  input  wire logic                         clk_en,
  input  wire logic                         osc_in,
  input  wire logic                         iface_sun_pulse,
  input  wire logic                         delayed_sun_mode_toggle,
  input  wire logic                         ad_start,
  output logic [sstc_pkg::CNT_W-1:0]        count_out,
  output logic [sstc_pkg::SECTOR_W-1:0]     sector_out,
  output sstc_pkg::sstc_strobe_t            strobes,
  output sstc_pkg::sstc_lock_t              lock_status,
  output logic                              freq_lower,
  output logic                              sun_pulse,
  output logic                              osc_tick_n,
  output logic                              ad_clock
);
  import sstc_pkg::*;

  typedef enum logic [1:0] {AD_IDLE, AD_WAIT, AD_RUN} sstc_ad_t;

  // three-stage input synchronisers; a change counts when stages two and three agree
  logic [2:0] osc_s_r, isp_s_r, mode_s_r, start_s_r;
  logic       osc_q_r, isp_q_r, mode_q_r, start_q_r;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      osc_s_r   <= 3'h0;
      isp_s_r   <= 3'h0;
      mode_s_r  <= 3'h0;
      start_s_r <= 3'h0;
    end else if (clk_en) begin
      osc_s_r   <= {osc_s_r[1:0], osc_in};
      isp_s_r   <= {isp_s_r[1:0], iface_sun_pulse};
      mode_s_r  <= {mode_s_r[1:0], delayed_sun_mode_toggle};
      start_s_r <= {start_s_r[1:0], ad_start};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      osc_q_r   <= 1'b0;
      isp_q_r   <= 1'b0;
      mode_q_r  <= 1'b0;
      start_q_r <= 1'b0;
    end else if (clk_en) begin
      if (osc_s_r[1] == osc_s_r[2]) osc_q_r <= osc_s_r[2];
      if (isp_s_r[1] == isp_s_r[2]) isp_q_r <= isp_s_r[2];
      if (mode_s_r[1] == mode_s_r[2]) mode_q_r <= mode_s_r[2];
      if (start_s_r[1] == start_s_r[2]) start_q_r <= start_s_r[2];
    end
  end

  logic isp_rise, mode_rise, start_rise, osc_rise;
  assign isp_rise   = (isp_s_r[1] == isp_s_r[2]) && isp_s_r[2] && !isp_q_r;
  assign mode_rise  = (mode_s_r[1] == mode_s_r[2]) && mode_s_r[2] && !mode_q_r;
  assign start_rise = (start_s_r[1] == start_s_r[2]) && start_s_r[2] && !start_q_r;
  assign osc_rise   = (osc_s_r[1] == osc_s_r[2]) && osc_s_r[2] && !osc_q_r;

  // path select and delay path
  logic path_direct_r, delay_tog_r, delay_tog_d_r, delay_run_r, delay_run_d_r;
  logic [31:0] delay_cnt_r;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      path_direct_r <= 1'b1;
    end else if (clk_en && mode_rise) begin
      path_direct_r <= !path_direct_r;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      delay_tog_r   <= 1'b0;
      delay_tog_d_r <= 1'b0;
    end else if (clk_en) begin
      if (isp_rise) delay_tog_r <= !delay_tog_r;
      delay_tog_d_r <= delay_tog_r;
    end
  end

  // a second pulse during a running delay leaves it running; only the rising toggle starts or restarts it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      delay_run_r <= 1'b0;
      delay_cnt_r <= 32'h0;
    end else if (clk_en) begin
      if (delay_tog_r && !delay_tog_d_r) begin
        delay_run_r <= 1'b1;
        delay_cnt_r <= 32'h0;
      end else if (delay_run_r) begin
        if (delay_cnt_r == 32'(DELAY_CYCLES - 2)) delay_run_r <= 1'b0;
        delay_cnt_r <= delay_cnt_r + 32'h1;
      end
    end
  end

  logic delay_shot, int_sun;
  always_ff @(posedge clock) begin
    if (!rst_n) delay_run_d_r <= 1'b0;
    else if (clk_en) delay_run_d_r <= delay_run_r;
  end
  assign delay_shot = delay_run_d_r && !delay_run_r;
  assign int_sun    = path_direct_r ? isp_rise : delay_shot;

  always_ff @(posedge clock) begin
    if (!rst_n) sun_pulse <= 1'b0;
    else if (clk_en) sun_pulse <= int_sun;
  end

  // squared oscillator kept inverted in its own flop, so the pin comes straight from a register
  always_ff @(posedge clock) begin
    if (!rst_n) osc_tick_n <= 1'b1;
    else if (clk_en) begin
      if (int_sun) osc_tick_n <= 1'b1;
      else if (osc_rise) osc_tick_n <= !osc_tick_n;
    end
  end
  logic tick;
  assign tick = osc_rise && !int_sun && !osc_tick_n;

  logic [CNT_W-1:0] cnt_r;
  logic ovf_r, st1_r, st2_r;
  always_ff @(posedge clock) begin
    if (!rst_n) cnt_r <= CNT_ZERO;
    else if (clk_en) begin
      if (int_sun) cnt_r <= CNT_ZERO;
      else if (tick) cnt_r <= cnt_r + 11'h001;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) ovf_r <= 1'b0;
    else if (clk_en) begin
      if (int_sun) ovf_r <= 1'b0;
      else if (tick && cnt_r == CNT_LAST) ovf_r <= 1'b1;
    end
  end

  // shift register samples the overflow of the revolution just ended
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st1_r <= 1'b0;
      st2_r <= 1'b0;
    end else if (clk_en && int_sun) begin
      st2_r <= ovf_r;
      st1_r <= st2_r;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) freq_lower <= 1'b0;
    else if (clk_en && int_sun) freq_lower <= ovf_r;
  end

  // sector decode
  logic [SECTOR_W-1:0] sec;
  assign sec = cnt_r[CNT_W-1:SECTOR_LSB];
  sstc_strobe_t stb;
  always_comb begin
    stb = '0;
    stb.sec_0_15     = (sec <= 7'h0f);
    stb.sec_1        = (sec == 7'h01);
    stb.sec_2_7      = (sec >= 7'h02) && (sec <= 7'h07);
    stb.sec_10       = (sec == 7'h0a);
    stb.sec_15       = (sec == 7'h0f);
    stb.sec_64_79    = (sec >= 7'h40) && (sec <= 7'h4f);
    stb.sec_16_80    = (sec == 7'h10) || (sec == 7'h50);
    stb.sec_selected = stb.sec_16_80 || stb.sec_64_79 || (sec == 7'h28) || (sec == 7'h38)
                       || (sec == 7'h58) || (sec == 7'h68) || (sec == 7'h7e);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count_out   <= CNT_ZERO;
      sector_out  <= 7'h00;
      strobes     <= '0;
      lock_status <= '0;
    end else if (clk_en) begin
      count_out   <= cnt_r;
      sector_out  <= sec;
      strobes     <= stb;
      lock_status <= '{overflow: ovf_r, stage1: st1_r, stage2: st2_r};
    end
  end

  // a/d clock: start gated, fixed rate
  sstc_ad_t  ad_st_r;
  logic [15:0] ad_cnt_r;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ad_st_r  <= AD_IDLE;
      ad_cnt_r <= 16'h0;
      ad_clock <= 1'b0;
    end else if (clk_en) begin
      case (ad_st_r)
        AD_IDLE: begin
          ad_clock <= 1'b0;
          if (start_rise) begin
            ad_st_r  <= AD_WAIT;
            ad_cnt_r <= 16'h0;
          end
        end
        AD_WAIT: begin
          ad_cnt_r <= ad_cnt_r + 16'h1;
          if (ad_cnt_r == 16'(AD_START_CYC - 1)) begin
            ad_st_r  <= AD_RUN;
            ad_cnt_r <= 16'h0;
            ad_clock <= 1'b1;
          end
        end
        AD_RUN: begin
          ad_cnt_r <= (ad_cnt_r == 16'(AD_PERIOD_CYC - 1)) ? 16'h0 : ad_cnt_r + 16'h1;
          ad_clock <= (ad_cnt_r == 16'(AD_PERIOD_CYC - 1))
                      || (ad_cnt_r < 16'(AD_PULSE_CYC - 1));
        end
        default: ad_st_r <= AD_IDLE;
      endcase
    end
  end

  a_cnt_clear: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && int_sun |=> cnt_r == CNT_ZERO && !ovf_r)
    else $error("counter not cleared by sun pulse");
  a_ovf_set: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && tick && cnt_r == CNT_LAST && !int_sun |=> ovf_r)
    else $error("overflow not flagged on wrap");
  a_stage_shift: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && int_sun |=> st2_r == $past(ovf_r) && st1_r == $past(st2_r))
    else $error("shift stages wrong after sun pulse");
  a_steer_match: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && int_sun |=> freq_lower == st2_r)
    else $error("steering level differs from stage two");
  a_direct_path: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && path_direct_r && isp_rise |=> sun_pulse)
    else $error("direct sun pulse not passed");
  a_delay_blocked: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && path_direct_r && delay_shot && !isp_rise |=> !sun_pulse)
    else $error("delayed pulse leaked in direct mode");
  a_delay_start: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && delay_tog_r && !delay_tog_d_r |=> delay_run_r && delay_cnt_r == 32'h0)
    else $error("delay not started");
  a_sector_map: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en |=> sector_out == count_out[CNT_W-1:SECTOR_LSB])
    else $error("sector not upper counter bits");
  a_ad_first: assert property (@(posedge clock) disable iff (!rst_n)
    ad_st_r == AD_WAIT && clk_en && ad_cnt_r == 16'(AD_START_CYC - 1) |=> ad_clock)
    else $error("first a/d pulse late");
  a_count_step: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && tick |=> cnt_r == $past(cnt_r) + 11'h001)
    else $error("counter did not advance on tick");
  a_tick_realign: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && int_sun |=> osc_tick_n)
    else $error("oscillator phase not realigned by sun pulse");
  a_stage_hold: assert property (@(posedge clock) disable iff (!rst_n)
    !(clk_en && int_sun) |=> $stable(st1_r) && $stable(st2_r))
    else $error("shift stages moved without sun pulse");
  a_steer_hold: assert property (@(posedge clock) disable iff (!rst_n)
    !(clk_en && int_sun) |=> $stable(freq_lower))
    else $error("steering level moved without sun pulse");
  a_lock_out: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en |=> lock_status == {$past(ovf_r), $past(st1_r), $past(st2_r)})
    else $error("lock status does not follow its flags");
  a_mode_toggle: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && mode_rise |=> path_direct_r != $past(path_direct_r))
    else $error("path select not toggled by mode change");
  a_delayed_pass: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && !path_direct_r && delay_shot |=> sun_pulse)
    else $error("delayed pulse not passed in delayed mode");
  a_direct_blocked: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && !path_direct_r && isp_rise && !delay_shot |=> !sun_pulse)
    else $error("interface pulse leaked in delayed mode");
  a_delay_end: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && delay_run_r && !(delay_tog_r && !delay_tog_d_r)
      && delay_cnt_r == 32'(DELAY_CYCLES - 2) |=> !delay_run_r && delay_shot)
    else $error("delay end did not fire the one-shot");
  a_ad_period: assert property (@(posedge clock) disable iff (!rst_n)
    ad_st_r == AD_RUN && clk_en && ad_cnt_r == 16'(AD_PERIOD_CYC - 1)
      |=> ad_clock && ad_cnt_r == 16'h0)
    else $error("a/d pulse not repeated at its period");
endmodule // sstc_top

// File: sstc_top_tb_top.sv
// testbench: sector decode, frequency lock, sun pulse paths and a/d clock
`timescale 1ns/1ps
module sstc_top_tb_top;
  import sstc_pkg::*;
  localparam int DLY = 50;
  logic                clock, rst_n, clk_en, tk;
  logic                osc_in, iface_sun_pulse, delayed_sun_mode_toggle, ad_start;
  logic [CNT_W-1:0]    count_out, cnt_after, c0;
  logic [SECTOR_W-1:0] sector_out;
  sstc_strobe_t        strobes;
  sstc_lock_t          lock_status;
  logic                freq_lower, sun_pulse, osc_tick_n, ad_clock;
  int num_errors = 0, checks_done = 0, cyc = 0, sun_cnt = 0, sun_at = -100, n0, t0, i;
  int          row_cnt [11] = '{0, 16, 32, 160, 240, 256, 640, 1024, 1280, 1936, 2016};
  logic [7:0]  row_stb [11] = '{8'h80, 8'hc0, 8'ha0, 8'h90, 8'h88, 8'h03, 8'h01, 8'h05,
                                8'h03, 8'h00, 8'h01};

  sstc_top #(.DELAY_CYCLES(DLY)) u_sstc_top (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .osc_in(osc_in), .iface_sun_pulse(iface_sun_pulse), .ad_start(ad_start),
    .delayed_sun_mode_toggle(delayed_sun_mode_toggle), .count_out(count_out),
    .sector_out(sector_out), .strobes(strobes), .lock_status(lock_status),
    .freq_lower(freq_lower), .sun_pulse(sun_pulse), .osc_tick_n(osc_tick_n),
    .ad_clock(ad_clock));
  sstc_far_side u_sstc_far_side (.clock(clock), .osc_in(osc_in),
    .iface_sun_pulse(iface_sun_pulse), .delayed_sun_mode_toggle(delayed_sun_mode_toggle),
    .ad_start(ad_start));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // sun pulses are one cycle wide, so they are counted here rather than polled
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (sun_pulse === 1'b1) begin
      sun_cnt = sun_cnt + 1;
      sun_at = cyc;
    end
    if (cyc == sun_at + 3) cnt_after = count_out;
  end

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
    end
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic pulse_sun(input int win, input int exp_n, input int lo, input int hi);
    n0 = sun_cnt;
    t0 = cyc;
    u_sstc_far_side.strobe(0);
    tick(win);
    check(sun_cnt - n0, exp_n);
    if (exp_n > 0) check(sun_at - t0 >= lo && sun_at - t0 <= hi, 1);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    num_errors++;
    $display("test watchdog expired");
    conclude();
  end

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    tick(2);
    check({count_out, lock_status, freq_lower, sun_pulse, ad_clock}, 0);
    check(osc_tick_n, 1);
    rst_n = 1'b1;
    $display("test reset done");
    tick(2);
    for (i = 0; i < 11; i++) begin
      while (count_out !== row_cnt[i][CNT_W-1:0] && cyc < 30000) tick(1);
      tick(2);
      check(sector_out, row_cnt[i] >> SECTOR_LSB);
      check(strobes, row_stb[i]);
    end
    $display("test sectors done");
    n0 = 0;
    for (i = 0; i < 32; i++) begin
      tk = osc_tick_n;
      tick(1);
      if (osc_tick_n !== tk) n0++;
    end
    check(n0, 8);
    c0 = count_out;
    tick(64);
    check(CNT_W'(count_out - c0), 8);
    clk_en = 1'b0;
    tick(2);
    c0 = count_out;
    tick(20);
    check(count_out, c0);
    clk_en = 1'b1;
    while (count_out !== CNT_ZERO && cyc < 40000) tick(1);
    tick(4);
    check(lock_status, 3'b100);
    pulse_sun(20, 1, 1, 12);
    check(cnt_after <= 1, 1);
    check({lock_status, freq_lower}, 4'b0011);
    pulse_sun(20, 1, 1, 12);
    check({lock_status, freq_lower}, 4'b0100);
    pulse_sun(DLY + 40, 1, 1, 12);
    check(lock_status, 3'b000);
    $display("test lock done");
    u_sstc_far_side.strobe(1);
    pulse_sun(DLY + 40, 0, 0, 0);
    pulse_sun(DLY + 40, 1, DLY, DLY + 14);
    u_sstc_far_side.strobe(1);
    pulse_sun(20, 1, 1, 12);
    $display("test delay done");
    t0 = cyc;
    u_sstc_far_side.strobe(2);
    while (ad_clock !== 1'b1 && cyc < t0 + 1000) tick(1);
    check(cyc - t0 >= AD_START_CYC && cyc - t0 <= AD_START_CYC + 10, 1);
    n0 = cyc;
    while (ad_clock === 1'b1 && cyc < n0 + 1000) tick(1);
    check(cyc - n0, AD_PULSE_CYC);
    while (ad_clock !== 1'b1 && cyc < n0 + 2000) tick(1);
    check(cyc - n0, AD_PERIOD_CYC);
    $display("test adc done");
    conclude();
  end
endmodule // sstc_top_tb_top
